/* File: hw/bwep_pkg.sv */
// constants for the block write/execute protection logic
// assumes a one-bit-wide serial i/o space addressed by bit displacement
// Notes on behaviour
// RULE_01: i/o reset clears all control bits
// RULE_02: polarity jumper inverts write-protect bit meaning
// RULE_03: write-protect bits reset to zero, unprotected
// RULE_04: global switch protects all blocks regardless
// RULE_05: four blocks, one write-protect bit each
// RULE_06: bits 0 to 3 read back written value
// RULE_07: fetch from protected block flags violation
// RULE_08: bits 4 to 7 execute protect, readback
// RULE_09: write violation latches, bit 8, lamp
// RULE_10: execute violation latches, bit 9, lamp
// RULE_11: latched indicator ignores further violations
// RULE_12: bit 8 one clears, zero rearms
// RULE_13: bit 11 zero clears, one rearms
// RULE_14: interrupt only on selected level
// RULE_15: execute violation never deselects memory
// RULE_16: board window is sixteen consecutive bits
// RULE_17: indicators set and hold until cleared
// RULE_18: protected block write strobe suppressed
// RULE_19: bit 9 write removes board memory
// RULE_20: any board access sets accessed indicator
// RULE_21: bit 10 reads switch, writes user lamp
// RULE_22: bits 12 to 15 are flag bits

package bwep_pkg;
   localparam int NUM_BLOCKS = 4;
   localparam int WINDOW_BITS = 4;          // 16 i/o bits per board
   localparam logic [3:0] BIT_WP0 = 4'h0;   // bits 0..3
   localparam logic [3:0] BIT_XP0 = 4'h4;   // bits 4..7
   localparam logic [3:0] BIT_VIOL_CLR = 4'h8;
   localparam logic [3:0] BIT_XVIOL_REMOVE = 4'h9;
   localparam logic [3:0] BIT_SWITCH_LAMP = 4'ha;
   localparam logic [3:0] BIT_ACCESSED = 4'hb;
   localparam logic [3:0] BIT_FLAG0 = 4'hc; // bits 12..15
   localparam logic [3:0] WP_RESET = 4'h0;
   localparam logic [3:0] XP_RESET = 4'h0;
   localparam logic [3:0] FLAG_RESET = 4'h0;
   localparam logic VIOL_CLR_RESET = 1'b0;
   localparam logic ACC_ARM_RESET = 1'b0;
   localparam logic REMOVE_RESET = 1'b0;
   localparam logic USER_LAMP_RESET = 1'b0;
endpackage

/* File: hw/bwep_latch.sv */
// set-and-hold indicator with a level clear
// set and clear come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module bwep_latch (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // control
   input wire logic set_evt,
   input wire logic clr_hold,
   // state
   output logic q
);
   logic q_r;
   logic q_nxt;

   // clear level holds the latch empty, as the clear pin of a flip-flop would
   always_comb begin
      q_nxt = q_r;
      if (clr_hold) begin
         q_nxt = 1'b0; // RULE_17
      end else if (set_evt) begin
         q_nxt = 1'b1; // RULE_11
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         q_r <= 1'b0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign q = q_r;
endmodule
`default_nettype wire

/* File: hw/bwep_top.sv */
// block write/execute protection for a battery-backed memory board
// assumes the host decodes its memory range into mem_access and the block index,
// and reaches control bits one at a time over a plain bit-addressed port
`timescale 1ns/1ps
`default_nettype none
module bwep_top #(
   parameter int IO_ADDR_W = 12,
   parameter int NUM_LEVELS = 4,
   parameter logic [IO_ADDR_W-5:0] BOARD_BASE = 8'h00
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // bit-serial i/o port
   input wire logic [IO_ADDR_W-1:0] io_addr,
   input wire logic io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   output logic io_rdata,
   // memory bus side, already range decoded
   input wire logic mem_access,
   input wire logic mem_write,
   input wire logic mem_fetch,
   input wire logic [1:0] mem_block,
   output logic mem_select,
   output logic mem_write_enable,
   // straps and switches on pins
   input wire logic protect_polarity_jumper,
   input wire logic global_write_protect_switch,
   input wire logic [NUM_LEVELS-1:0] interrupt_level_selector,
   // lamps and interrupts
   output logic write_violation_lamp,
   output logic execute_violation_lamp,
   output logic user_lamp,
   output logic [NUM_LEVELS-1:0] int_request
);
   localparam int PIN_W = NUM_LEVELS + 2;

   // control bits
   logic [bwep_pkg::NUM_BLOCKS-1:0] wp_r, wp_nxt;
   logic [bwep_pkg::NUM_BLOCKS-1:0] xp_r, xp_nxt;
   logic [3:0] flag_r, flag_nxt;
   logic viol_clr_r, viol_clr_nxt;
   logic acc_arm_r, acc_arm_nxt;
   logic remove_r, remove_nxt;
   logic user_lamp_r, user_lamp_nxt;
   // pin synchroniser
   logic [PIN_W-1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r, pin_f_nxt;
   logic polarity_f;
   logic switch_protect_f;
   logic [NUM_LEVELS-1:0] level_f;
   // decode and protection
   logic board_hit;
   logic [3:0] bit_sel;
   logic [bwep_pkg::NUM_BLOCKS-1:0] blk_wprot;
   logic live_access;
   logic wv_set, xv_set, acc_set;
   logic wv_q, xv_q, acc_q;
   // registered outputs
   logic io_rdata_r, io_rdata_nxt;
   logic mem_select_r, mem_select_nxt;
   logic mem_we_r, mem_we_nxt;
   logic wlamp_r, wlamp_nxt;
   logic xlamp_r, xlamp_nxt;
   logic [NUM_LEVELS-1:0] int_r, int_nxt;
   logic rd_bit;

   // straps may move at any time; a level counts once stages two and three agree
   always_comb begin
      pin_f_nxt = pin_f_r;
      for (int i = 0; i < PIN_W; i++) begin
         if (pin_s2_r[i] == pin_s3_r[i]) begin
            pin_f_nxt[i] = pin_s3_r[i];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         pin_s3_r <= '0;
         pin_f_r <= '0;
      end else begin
         pin_s1_r <= {interrupt_level_selector, global_write_protect_switch, protect_polarity_jumper};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         pin_f_r <= pin_f_nxt;
      end
   end

   assign polarity_f = pin_f_r[0];
   assign switch_protect_f = pin_f_r[1];
   assign level_f = pin_f_r[PIN_W-1:2];

   // sixteen-bit window per board, so a neighbour starts at base plus 16
   assign board_hit = (io_addr[IO_ADDR_W-1:bwep_pkg::WINDOW_BITS] == BOARD_BASE); // RULE_16
   assign bit_sel = io_addr[bwep_pkg::WINDOW_BITS-1:0];

   // i/o writes into control bits
   always_comb begin
      wp_nxt = wp_r;
      xp_nxt = xp_r;
      flag_nxt = flag_r;
      viol_clr_nxt = viol_clr_r;
      acc_arm_nxt = acc_arm_r;
      remove_nxt = remove_r;
      user_lamp_nxt = user_lamp_r;
      if (io_wr && board_hit) begin
         unique case (bit_sel[3:2])
            2'h0: begin
               wp_nxt[bit_sel[1:0]] = io_wdata; // RULE_05
            end
            2'h1: begin
               xp_nxt[bit_sel[1:0]] = io_wdata; // RULE_08
            end
            2'h2: begin
               unique case (bit_sel[1:0])
                  2'h0: viol_clr_nxt = io_wdata; // RULE_12
                  2'h1: remove_nxt = io_wdata; // RULE_19
                  2'h2: user_lamp_nxt = io_wdata; // RULE_21
                  2'h3: acc_arm_nxt = io_wdata; // RULE_13
               endcase
            end
            2'h3: begin
               flag_nxt[bit_sel[1:0]] = io_wdata; // RULE_22
            end
         endcase
      end
   end

   // everything clears on i/o reset, leaving lamps dark and memory open while the polarity jumper and switch are off
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wp_r <= bwep_pkg::WP_RESET; // RULE_03
         xp_r <= bwep_pkg::XP_RESET; // RULE_01
         flag_r <= bwep_pkg::FLAG_RESET;
         viol_clr_r <= bwep_pkg::VIOL_CLR_RESET;
         acc_arm_r <= bwep_pkg::ACC_ARM_RESET;
         remove_r <= bwep_pkg::REMOVE_RESET;
         user_lamp_r <= bwep_pkg::USER_LAMP_RESET;
      end else begin
         wp_r <= wp_nxt;
         xp_r <= xp_nxt;
         flag_r <= flag_nxt;
         viol_clr_r <= viol_clr_nxt;
         acc_arm_r <= acc_arm_nxt;
         remove_r <= remove_nxt;
         user_lamp_r <= user_lamp_nxt;
      end
   end

   // per-block protection; jumper flips the sense of the software bits
   always_comb begin
      for (int b = 0; b < bwep_pkg::NUM_BLOCKS; b++) begin
         blk_wprot[b] = switch_protect_f | (wp_r[b] ^ polarity_f); // RULE_02 RULE_04
      end
   end

   // a removed board sees no access at all, so nothing latches either
   assign live_access = mem_access & ~remove_r; // RULE_19
   assign wv_set = live_access & mem_write & blk_wprot[mem_block]; // RULE_09
   assign xv_set = live_access & mem_fetch & xp_r[mem_block]; // RULE_07
   assign acc_set = live_access; // RULE_20

   // write and execute latches share the bit 8 clear; one holds them empty
   bwep_latch u_wv_latch (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .set_evt(wv_set),
      .clr_hold(viol_clr_r), // RULE_12
      .q(wv_q)
   );

   bwep_latch u_xv_latch (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .set_evt(xv_set),
      .clr_hold(viol_clr_r), // RULE_12
      .q(xv_q)
   );

   // accessed latch clears on a zero, the opposite sense of bit 8
   bwep_latch u_acc_latch (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .set_evt(acc_set),
      .clr_hold(~acc_arm_r), // RULE_13
      .q(acc_q)
   );

   // read mux, one bit per displacement
   always_comb begin
      rd_bit = 1'b0;
      unique case (bit_sel[3:2])
         2'h0: rd_bit = wp_r[bit_sel[1:0]]; // RULE_06
         2'h1: rd_bit = xp_r[bit_sel[1:0]]; // RULE_08
         2'h2: begin
            unique case (bit_sel[1:0])
               2'h0: rd_bit = wv_q; // RULE_09
               2'h1: rd_bit = xv_q; // RULE_10
               2'h2: rd_bit = ~switch_protect_f; // RULE_21
               2'h3: rd_bit = acc_q; // RULE_20
            endcase
         end
         2'h3: rd_bit = flag_r[bit_sel[1:0]]; // RULE_22
      endcase
   end

   // outputs; the fetch path never gates select, only the lamp and interrupt
   always_comb begin
      io_rdata_nxt = io_rd & board_hit & rd_bit;
      mem_select_nxt = live_access; // RULE_15
      mem_we_nxt = live_access & mem_write & ~blk_wprot[mem_block]; // RULE_18
      wlamp_nxt = wv_q; // RULE_09
      xlamp_nxt = xv_q; // RULE_10
      int_nxt = level_f & {NUM_LEVELS{wv_q | xv_q}}; // RULE_14
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         io_rdata_r <= 1'b0;
         mem_select_r <= 1'b0;
         mem_we_r <= 1'b0;
         wlamp_r <= 1'b0;
         xlamp_r <= 1'b0;
         int_r <= '0;
      end else begin
         io_rdata_r <= io_rdata_nxt;
         mem_select_r <= mem_select_nxt;
         mem_we_r <= mem_we_nxt;
         wlamp_r <= wlamp_nxt;
         xlamp_r <= xlamp_nxt;
         int_r <= int_nxt;
      end
   end

   assign io_rdata = io_rdata_r;
   assign mem_select = mem_select_r;
   assign mem_write_enable = mem_we_r;
   assign write_violation_lamp = wlamp_r;
   assign execute_violation_lamp = xlamp_r;
   assign user_lamp = user_lamp_r;
   assign int_request = int_r;
endmodule
`default_nettype wire

/* File: test/bwep_asserts.sv */
// port checker for the protection block
// assumes board base 0 and a single clock
`timescale 1ns/1ps
`default_nettype none
module bwep_asserts #(
   parameter int IO_ADDR_W = 12,
   parameter int NUM_LEVELS = 4
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // bit port
   input wire logic [IO_ADDR_W-1:0] io_addr,
   input wire logic io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic io_rdata,
   // memory side and pins
   input wire logic mem_access,
   input wire logic mem_write,
   input wire logic mem_fetch,
   input wire logic mem_select,
   input wire logic mem_write_enable,
   input wire logic global_write_protect_switch,
   // indicators
   input wire logic write_violation_lamp,
   input wire logic execute_violation_lamp,
   input wire logic [NUM_LEVELS-1:0] int_request
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // clear strobe on bit 8; the lamp lags it by two edges
   wire logic clr8 = io_wr && io_wdata && io_addr == 8;
   sequence wr_try;
      mem_access && mem_write;
   endsequence
   rd_one_shot_a: assert property (!$past(io_rd) |-> !io_rdata) else $error("stray read data");
   sel_idle_a: assert property (!mem_access |=> !mem_select) else $error("select without access");
   we_cause_a: assert property (mem_write_enable |-> $past(mem_access && mem_write))
      else $error("write enable without write");
   switch_prot_a: assert property (global_write_protect_switch [*6] ##0 wr_try |=> !mem_write_enable)
      else $error("write passed the switch");
   wv_cause_a: assert property ($rose(write_violation_lamp) |-> $past(mem_access && mem_write, 2))
      else $error("write lamp without write");
   xv_cause_a: assert property ($rose(execute_violation_lamp) |-> $past(mem_access && mem_fetch, 2))
      else $error("exec lamp without fetch");
   wv_hold_a: assert property (write_violation_lamp && !$past(clr8) && !$past(clr8, 2) |=> write_violation_lamp)
      else $error("write lamp dropped");
   int_cause_a: assert property (int_request != 0 |-> write_violation_lamp || execute_violation_lamp)
      else $error("interrupt without lamp");
endmodule
bind bwep_top bwep_asserts #(.IO_ADDR_W(IO_ADDR_W), .NUM_LEVELS(NUM_LEVELS)) bwep_asserts_inst (.ref_clk, .rst_b,
   .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata, .mem_access, .mem_write, .mem_fetch, .mem_select,
   .mem_write_enable, .global_write_protect_switch, .write_violation_lamp, .execute_violation_lamp, .int_request);
`default_nettype wire

/* File: test/bwep_host.sv */
// host model on the memory side of the protection block
// assumes select and write enable arrive one cycle after the access
`timescale 1ns/1ps
`default_nettype none
module bwep_host (
   // clock
   input wire logic ref_clk,
   // memory bus
   output logic mem_access,
   output logic mem_write,
   output logic mem_fetch,
   output logic [1:0] mem_block,
   input wire logic mem_select,
   input wire logic mem_write_enable
);
   logic seen_sel = 1'b0;
   logic seen_we = 1'b0;
   initial {mem_access, mem_write, mem_fetch, mem_block} = 5'h00;
   // idle qualifiers show the inverse so no stale value looks valid
   task automatic cycle(input logic w, input logic f, input logic [1:0] b);
      @(posedge ref_clk);
      {mem_access, mem_write, mem_fetch, mem_block} <= {1'b1, w, f, b};
      @(posedge ref_clk);
      {mem_access, mem_write, mem_fetch, mem_block} <= {1'b0, ~w, ~f, ~b};
      @(negedge ref_clk);
      seen_sel = mem_select;
      seen_we = mem_write_enable;
   endtask
endmodule
`default_nettype wire

/* File: test/tb_bwep_top.sv */
// self-checking bench for the protection block
// assumes board base 0; memory cycles come from the host model
`timescale 1ns/1ps
`default_nettype none
module tb_bwep_top;
   logic ref_clk = 1'b0, rst_b = 1'b0, io_wdata = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
   logic protect_polarity_jumper = 1'b0, global_write_protect_switch = 1'b0;
   logic [11:0] io_addr = 12'h000;
   logic [3:0] interrupt_level_selector = 4'h2;
   logic io_rdata, mem_access, mem_write, mem_fetch, mem_select, mem_write_enable, user_lamp;
   logic write_violation_lamp, execute_violation_lamp;
   logic [1:0] mem_block;
   logic [3:0] int_request;
   int failures = 0, comparisons = 0;
   bwep_top bwep_top_inst (.ref_clk, .rst_b, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata, .mem_access,
      .mem_write, .mem_fetch, .mem_block, .mem_select, .mem_write_enable, .protect_polarity_jumper,
      .global_write_protect_switch, .interrupt_level_selector, .write_violation_lamp,
      .execute_violation_lamp, .user_lamp, .int_request);
   bwep_host bwep_host_inst (.ref_clk, .mem_access, .mem_write, .mem_fetch, .mem_block, .mem_select,
      .mem_write_enable);
   initial forever #25 ref_clk = ~ref_clk;
   task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic v);
      @(posedge ref_clk);
      {io_wr, io_addr, io_wdata} <= {1'b1, a, v};
      @(posedge ref_clk);
      io_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, input logic e);
      @(posedge ref_clk);
      {io_rd, io_addr} <= {1'b1, a};
      @(posedge ref_clk);
      io_rd <= 1'b0;
      @(negedge ref_clk);
      chk("io_rdata", {3'h0, e}, {3'h0, io_rdata});
   endtask
   task automatic close_out;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge ref_clk);
      // after reset only bit 10 reads one, the switch being off
      for (int i = 0; i < 16; i++) rd(12'(i), i == 10);
      for (int i = 0; i < 16; i++) if (i < 8 || i > 11) begin
         wr(12'(i), 1'b1);
         rd(12'(i), 1'b1);
      end
      rd(12'h010, 1'b0);
      // a write to the neighbouring board must leave our bits alone
      wr(12'h014, 1'b0);
      rd(12'h004, 1'b1);
      wr(12'h00b, 1'b1);
      bwep_host_inst.cycle(1'b1, 1'b0, 2'h2);
      chk("we", 4'h0, {3'h0, bwep_host_inst.seen_we});
      rd(12'h008, 1'b1);
      rd(12'h00b, 1'b1);
      chk("wv_lamp", 4'h1, {3'h0, write_violation_lamp});
      chk("int", 4'h2, int_request);
      bwep_host_inst.cycle(1'b0, 1'b1, 2'h1);
      chk("sel", 4'h1, {3'h0, bwep_host_inst.seen_sel});
      rd(12'h009, 1'b1);
      chk("xv_lamp", 4'h1, {3'h0, execute_violation_lamp});
      chk("int", 4'h2, int_request);
      // a held clear swallows violations until re-armed
      wr(12'h008, 1'b1);
      bwep_host_inst.cycle(1'b1, 1'b0, 2'h0);
      rd(12'h008, 1'b0);
      rd(12'h009, 1'b0);
      wr(12'h008, 1'b0);
      bwep_host_inst.cycle(1'b1, 1'b0, 2'h3);
      rd(12'h008, 1'b1);
      wr(12'h00b, 1'b0);
      bwep_host_inst.cycle(1'b0, 1'b0, 2'h0);
      rd(12'h00b, 1'b0);
      wr(12'h00b, 1'b1);
      bwep_host_inst.cycle(1'b0, 1'b0, 2'h0);
      rd(12'h00b, 1'b1);
      // inverted polarity: ones unprotect, block 1 alone set to zero
      @(posedge ref_clk);
      protect_polarity_jumper <= 1'b1;
      wr(12'h001, 1'b0);
      repeat (5) @(posedge ref_clk);
      bwep_host_inst.cycle(1'b1, 1'b0, 2'h0);
      chk("we", 4'h1, {3'h0, bwep_host_inst.seen_we});
      bwep_host_inst.cycle(1'b1, 1'b0, 2'h1);
      chk("we", 4'h0, {3'h0, bwep_host_inst.seen_we});
      @(posedge ref_clk);
      global_write_protect_switch <= 1'b1;
      repeat (6) @(posedge ref_clk);
      bwep_host_inst.cycle(1'b1, 1'b0, 2'h0);
      chk("we", 4'h0, {3'h0, bwep_host_inst.seen_we});
      rd(12'h00a, 1'b0);
      wr(12'h00a, 1'b1);
      @(negedge ref_clk);
      chk("user_lamp", 4'h1, {3'h0, user_lamp});
      wr(12'h009, 1'b1);
      bwep_host_inst.cycle(1'b0, 1'b0, 2'h0);
      chk("sel", 4'h0, {3'h0, bwep_host_inst.seen_sel});
      wr(12'h009, 1'b0);
      bwep_host_inst.cycle(1'b0, 1'b0, 2'h0);
      chk("sel", 4'h1, {3'h0, bwep_host_inst.seen_sel});
      // no level selected: the lamp alone shows the latched violation
      @(posedge ref_clk);
      interrupt_level_selector <= 4'h0;
      repeat (7) @(negedge ref_clk);
      chk("int", 4'h0, int_request);
      chk("wv_lamp", 4'h1, {3'h0, write_violation_lamp});
      // second reset in mid-run clears the control bits again
      @(posedge ref_clk);
      rst_b <= 1'b0;
      @(posedge ref_clk);
      rst_b <= 1'b1;
      rd(12'h004, 1'b0);
      close_out();
   end
endmodule
`default_nettype wire
